/* logic/prs_pkg.sv */
package prs_pkg;

	typedef enum logic [3:0] {
		OP_NONE,
		OP_SEQ,
		OP_JUMP,
		OP_CALL,
		OP_IRQ_HI,
		OP_IRQ_LO,
		OP_RET,
		OP_UNLINK,
		OP_PUSH,
		OP_POP
	} prs_op_e;

	typedef struct packed {
		prs_op_e op;
		logic [20:0] target;
	} prs_core_req_s;

	typedef struct packed {
		logic [20:0] pc;
		logic [7:0] high_latch;
		logic [4:0] upper_latch;
		logic [4:0] sp;
		logic full;
		logic unf;
		logic [31:1][20:0] stk;
		logic [15:0] cfg_one;
		logic [15:0] cfg_two;
		logic [15:0] cfg_three;
		logic cfg_done;
		logic fault;
		logic [15:0] fword;
		logic [31:0] prdata;
	} prs_state_s;

endpackage : prs_pkg

/* logic/prs_regs.svh */
`ifndef PRS_REGS_SVH
`define PRS_REGS_SVH

// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define PRS_OFS_PC_LOW 8'h00
`define PRS_OFS_PC_HIGH_LATCH 8'h04
`define PRS_OFS_PC_UPPER_LATCH 8'h08
`define PRS_OFS_STACK_POINTER 8'h0C
`define PRS_OFS_TOS_LOW 8'h10
`define PRS_OFS_TOS_HIGH 8'h14
`define PRS_OFS_TOS_UPPER 8'h18
`define PRS_OFS_CONFIG_ONE 8'h1C

// ----------------------------------------
// fields and constants
// ----------------------------------------
`define PRS_SP_FULL_BIT 7
`define PRS_SP_UNF_BIT 6
`define PRS_CFG_STACK_FAULT_RESET_ENABLE_BIT 0
`define PRS_RESET_VECTOR 21'h0_0000
`define PRS_HI_VECTOR 21'h0_0008
`define PRS_LO_VECTOR 21'h0_0018
`define PRS_PROG_TOP 21'h0_7FFF
`define PRS_PC_STEP 21'h0_0002
`define PRS_STACK_TOP 5'h1F
`define PRS_SP_RESET 5'h00

`endif

/* logic/prs_top.sv */
`timescale 1ns/1ps
`include "prs_regs.svh"

module prs_top (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic [31:0] paddr,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire prs_pkg::prs_core_req_s core_req,
	input wire logic ext_set_enable,
	input wire logic [15:0] fetch_data,
	input wire logic [63:0] cfg_image,
	output logic [20:0] fetch_addr,
	output logic [15:0] fetch_word,
	output logic stack_fault_reset
);

	prs_pkg::prs_state_s s;
	prs_pkg::prs_state_s next_s;

	// ----------------------------------------
	// decode helpers
	// ----------------------------------------
	function automatic logic is_mapped(input logic [31:0] a);
		is_mapped = (a[31:8] == 24'h00_0000) && (a[1:0] == 2'b00) && (a[7:0] <= `PRS_OFS_CONFIG_ONE);
	endfunction : is_mapped

	function automatic logic [20:0] tos_of(input prs_pkg::prs_state_s st);
		tos_of = (st.sp == `PRS_SP_RESET) ? 21'h0_0000 : st.stk[st.sp];
	endfunction : tos_of

	function automatic logic [15:0] read_reg(input logic [7:0] a, input prs_pkg::prs_state_s st);
		logic [20:0] t;
		t = tos_of(st);
		read_reg = 16'h0000;
		unique case (a)
			`PRS_OFS_PC_LOW: read_reg = {8'h00, st.pc[7:0]};
			`PRS_OFS_PC_HIGH_LATCH: read_reg = {8'h00, st.high_latch};
			`PRS_OFS_PC_UPPER_LATCH: read_reg = {11'h000, st.upper_latch};
			`PRS_OFS_STACK_POINTER: read_reg = {8'h00, st.full, st.unf, 1'b0, st.sp};
			`PRS_OFS_TOS_LOW: read_reg = {8'h00, t[7:0]};
			`PRS_OFS_TOS_HIGH: read_reg = {8'h00, t[15:8]};
			`PRS_OFS_TOS_UPPER: read_reg = {11'h000, t[20:16]};
			`PRS_OFS_CONFIG_ONE: read_reg = st.cfg_one;
			default: read_reg = 16'h0000;
		endcase
	endfunction : read_reg

	logic apb_setup;
	logic apb_acc;
	logic apb_wr;
	logic stack_fault_reset_enable;
	logic do_push;
	logic do_pop;
	logic [20:0] tos_value;

	assign apb_setup = psel && !penable;
	assign apb_acc = psel && penable && is_mapped(paddr);
	assign apb_wr = apb_acc && pwrite;
	assign stack_fault_reset_enable = s.cfg_one[`PRS_CFG_STACK_FAULT_RESET_ENABLE_BIT];
	assign tos_value = tos_of(s);
	assign do_push = (core_req.op == prs_pkg::OP_CALL) || (core_req.op == prs_pkg::OP_IRQ_HI)
		|| (core_req.op == prs_pkg::OP_IRQ_LO) || (core_req.op == prs_pkg::OP_PUSH);
	assign do_pop = (core_req.op == prs_pkg::OP_RET) || (core_req.op == prs_pkg::OP_POP)
		|| ((core_req.op == prs_pkg::OP_UNLINK) && ext_set_enable);

	// ----------------------------------------
	// next state
	// ----------------------------------------
	always_comb begin
		logic [4:0] sp1;
		logic [20:0] ret_pc;
		sp1 = 5'h00;
		ret_pc = 21'h0_0000;
		next_s = s;
		next_s.fault = 1'b0;
		next_s.fword = (s.pc > `PRS_PROG_TOP) ? 16'h0000 : fetch_data;
		// first cycle after release: config words from the top of memory, ascending bytes
		if (!s.cfg_done) begin
			next_s.cfg_one = cfg_image[15:0];
			next_s.cfg_two = cfg_image[31:16];
			next_s.cfg_three = cfg_image[47:32];
			next_s.cfg_done = 1'b1;
		end
		if (apb_setup) begin
			next_s.prdata = {16'h0000, read_reg(paddr[7:0], s)};
		end
		if (apb_wr) begin
			unique case (paddr[7:0])
				`PRS_OFS_PC_LOW: next_s.pc = {s.upper_latch, s.high_latch, pwdata[7:1], 1'b0};
				`PRS_OFS_PC_HIGH_LATCH: next_s.high_latch = pwdata[7:0];
				`PRS_OFS_PC_UPPER_LATCH: next_s.upper_latch = pwdata[4:0];
				`PRS_OFS_STACK_POINTER: begin
					next_s.sp = pwdata[4:0];
					// clear-only: a one written leaves the flag as it is
					next_s.full = s.full && pwdata[`PRS_SP_FULL_BIT];
					next_s.unf = s.unf && pwdata[`PRS_SP_UNF_BIT];
				end
				`PRS_OFS_TOS_LOW: if (s.sp != `PRS_SP_RESET) next_s.stk[s.sp][7:0] = pwdata[7:0];
				`PRS_OFS_TOS_HIGH: if (s.sp != `PRS_SP_RESET) next_s.stk[s.sp][15:8] = pwdata[7:0];
				`PRS_OFS_TOS_UPPER: if (s.sp != `PRS_SP_RESET) next_s.stk[s.sp][20:16] = pwdata[4:0];
				default: ;
			endcase
		end else if (apb_acc && (paddr[7:0] == `PRS_OFS_PC_LOW)) begin
			next_s.high_latch = s.pc[15:8];
			next_s.upper_latch = s.pc[20:16];
		end
		// core sequencing goes after software so a hardware flag set beats a clear
		if (do_push) begin
			if (next_s.sp == `PRS_STACK_TOP) begin
				next_s.full = 1'b1;
			end else begin
				sp1 = next_s.sp + 5'h01;
				if ((sp1 == `PRS_STACK_TOP) && stack_fault_reset_enable) begin
					next_s.stk[sp1] = next_s.pc + `PRS_PC_STEP;
					next_s.fault = 1'b1;
				end else begin
					next_s.stk[sp1] = next_s.pc;
				end
				next_s.sp = sp1;
				if (sp1 == `PRS_STACK_TOP) next_s.full = 1'b1;
			end
		end
		if (do_pop) begin
			if (next_s.sp == `PRS_SP_RESET) begin
				ret_pc = 21'h0_0000;
				next_s.unf = 1'b1;
				next_s.fault = stack_fault_reset_enable;
			end else begin
				ret_pc = next_s.stk[next_s.sp];
				next_s.sp = next_s.sp - 5'h01;
			end
		end
		// latches untouched by any of these
		unique case (core_req.op)
			prs_pkg::OP_SEQ: next_s.pc = next_s.pc + `PRS_PC_STEP;
			prs_pkg::OP_JUMP, prs_pkg::OP_CALL: next_s.pc = {core_req.target[20:1], 1'b0};
			prs_pkg::OP_IRQ_HI: next_s.pc = `PRS_HI_VECTOR;
			prs_pkg::OP_IRQ_LO: next_s.pc = `PRS_LO_VECTOR;
			prs_pkg::OP_RET: next_s.pc = {ret_pc[20:1], 1'b0};
			prs_pkg::OP_UNLINK: if (ext_set_enable) next_s.pc = {ret_pc[20:1], 1'b0};
			default: ;
		endcase
		// fault reset: pc, pointer and both latches go to reset values; flags, stack entries and config words survive
		if (next_s.fault) begin
			next_s.pc = `PRS_RESET_VECTOR;
			next_s.sp = `PRS_SP_RESET;
			next_s.high_latch = 8'h00;
			next_s.upper_latch = 5'h00;
		end
	end

	// ----------------------------------------
	// state register
	// ----------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end

	assign pready = 1'b1;
	assign pslverr = psel && penable && !is_mapped(paddr);
	assign prdata = s.prdata;
	assign fetch_addr = s.pc;
	assign fetch_word = s.fword;
	assign stack_fault_reset = s.fault;

	// ----------------------------------------
	// checks
	// ----------------------------------------
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	AST_PC_ALIGNED: assert property (s.pc[0] == 1'b0)
		else $error("pc bit zero set");
	AST_SEQ_STEP: assert property ((core_req.op == prs_pkg::OP_SEQ) && !apb_wr
		|=> s.pc == $past(s.pc) + `PRS_PC_STEP)
		else $error("sequential step not two");
	AST_VEC_HI: assert property ((core_req.op == prs_pkg::OP_IRQ_HI) && !apb_wr
		|=> s.fault || (s.pc == `PRS_HI_VECTOR))
		else $error("high vector not loaded");
	AST_FAULT_CLEARS: assert property (s.fault |-> (s.sp == `PRS_SP_RESET) && (s.pc == 21'h0_0000))
		else $error("fault reset left pointer or pc");
	AST_FULL_STICK: assert property (do_push && (s.sp == `PRS_STACK_TOP) && !apb_wr
		|=> (s.sp == `PRS_STACK_TOP) && s.full && $stable(tos_value))
		else $error("push past full moved pointer");
	AST_UNDERFLOW: assert property (do_pop && (s.sp == `PRS_SP_RESET) && !apb_wr
		|=> s.unf && (s.sp == `PRS_SP_RESET))
		else $error("underflow not flagged");
	AST_PUSH_ORDER: assert property (do_push && (s.sp < 5'h1E) && !apb_wr
		|=> (s.sp == $past(s.sp) + 5'h01) && (tos_value == $past(s.pc)))
		else $error("push pointer or value wrong");
	AST_FETCH_ZERO: assert property (s.pc > `PRS_PROG_TOP |=> s.fword == 16'h0000)
		else $error("fetch beyond memory not zero");
	AST_LATCH_XFER: assert property (apb_wr && (paddr[7:0] == `PRS_OFS_PC_LOW)
		&& (core_req.op == prs_pkg::OP_NONE)
		|=> s.pc[20:8] == {$past(s.upper_latch), $past(s.high_latch)})
		else $error("latches not moved into pc");
	AST_FULL_CAUSE: assert property ($rose(s.full) |-> $past(do_push))
		else $error("full flag set without push");

	// ----------------------------------------
	// checks: program counter loading
	// ----------------------------------------
	AST_VEC_LO: assert property ((core_req.op == prs_pkg::OP_IRQ_LO) && !apb_wr
		|=> s.fault || (s.pc == `PRS_LO_VECTOR))
		else $error("low vector not loaded");

	AST_JUMP_LOAD: assert property ((core_req.op == prs_pkg::OP_JUMP)
		|=> s.pc == {$past(core_req.target[20:1]), 1'b0})
		else $error("jump target not loaded");

	AST_CALL_LOAD: assert property ((core_req.op == prs_pkg::OP_CALL)
		|=> s.fault || (s.pc == {$past(core_req.target[20:1]), 1'b0}))
		else $error("call target not loaded");

	// reads of the pc low byte legally refresh the latches, so they are left out
	AST_LATCH_KEEP: assert property (((core_req.op == prs_pkg::OP_CALL)
		|| (core_req.op == prs_pkg::OP_RET)) && !apb_acc
		|=> s.fault || ($stable(s.high_latch) && $stable(s.upper_latch)))
		else $error("call or return touched a latch");

	AST_PC_LOW_READ: assert property (apb_acc && !pwrite && (paddr[7:0] == `PRS_OFS_PC_LOW)
		|=> s.fault || ((s.high_latch == $past(s.pc[15:8]))
		&& (s.upper_latch == $past(s.pc[20:16]))))
		else $error("pc low read did not fill latches");

	AST_HL_WRITE: assert property (apb_wr && (paddr[7:0] == `PRS_OFS_PC_HIGH_LATCH)
		|=> s.fault || (s.high_latch == $past(pwdata[7:0])))
		else $error("high latch write lost");

	AST_PROG_IN: assert property ((s.pc <= `PRS_PROG_TOP) |=> s.fword == $past(fetch_data))
		else $error("fetch inside memory altered");

	// ----------------------------------------
	// checks: return stack
	// ----------------------------------------
	AST_RET_POP: assert property ((core_req.op == prs_pkg::OP_RET) && (s.sp != `PRS_SP_RESET)
		&& !apb_wr |=> (s.sp == $past(s.sp) - 5'h01)
		&& (s.pc == {$past(tos_value[20:1]), 1'b0}))
		else $error("return pop wrong");

	AST_UNLINK_OFF: assert property ((core_req.op == prs_pkg::OP_UNLINK) && !ext_set_enable
		&& !apb_wr |=> $stable(s.sp) && $stable(s.pc))
		else $error("unlink acted while disabled");

	AST_POP_SW: assert property ((core_req.op == prs_pkg::OP_POP) && (s.sp != `PRS_SP_RESET)
		&& !apb_wr |=> (s.sp == $past(s.sp) - 5'h01) && $stable(s.pc))
		else $error("software pop wrong");

	AST_PUSH_SW: assert property ((core_req.op == prs_pkg::OP_PUSH) && (s.sp < 5'h1E)
		&& !apb_wr |=> $stable(s.pc))
		else $error("software push moved pc");

	AST_POP_ZERO: assert property ((core_req.op == prs_pkg::OP_RET)
		&& (s.sp == `PRS_SP_RESET) && !apb_wr |=> s.pc == 21'h0_0000)
		else $error("empty pop did not return zero");

	AST_PUSH_FULL_FAULT: assert property (do_push && (s.sp == 5'h1E) && stack_fault_reset_enable && !apb_wr
		|=> s.fault && s.full && (s.sp == `PRS_SP_RESET)
		&& (s.stk[5'h1F] == $past(s.pc) + `PRS_PC_STEP))
		else $error("full push with fault enable wrong");

	AST_PUSH_FULL_NOFAULT: assert property (do_push && (s.sp == 5'h1E) && !stack_fault_reset_enable && !apb_wr
		|=> !s.fault && s.full && (s.sp == `PRS_STACK_TOP))
		else $error("full push without fault enable wrong");

	AST_FAULT_CAUSE: assert property (s.fault |-> $past(stack_fault_reset_enable))
		else $error("fault reset while disabled");

	AST_NO_FAULT_OFF: assert property (!stack_fault_reset_enable |=> !s.fault)
		else $error("fault pulse with enable clear");

	AST_UNF_CAUSE: assert property ($rose(s.unf) |-> $past(do_pop))
		else $error("underflow set without pop");

	// ----------------------------------------
	// checks: software access to the stack
	// ----------------------------------------
	AST_SP_WRITE: assert property (apb_wr && (paddr[7:0] == `PRS_OFS_STACK_POINTER)
		&& (core_req.op == prs_pkg::OP_NONE) |=> s.sp == $past(pwdata[4:0]))
		else $error("pointer write lost");

	AST_TOS_WRITE: assert property (apb_wr && (paddr[7:0] == `PRS_OFS_TOS_LOW)
		&& (s.sp != `PRS_SP_RESET) && (core_req.op == prs_pkg::OP_NONE)
		|=> tos_value[7:0] == $past(pwdata[7:0]))
		else $error("top of stack write lost");

	AST_NO_SET_FULL: assert property (apb_wr && (paddr[7:0] == `PRS_OFS_STACK_POINTER)
		&& !s.full && (core_req.op == prs_pkg::OP_NONE) |=> !s.full)
		else $error("software set full flag");

	AST_NO_SET_UNF: assert property (apb_wr && (paddr[7:0] == `PRS_OFS_STACK_POINTER)
		&& !s.unf && (core_req.op == prs_pkg::OP_NONE) |=> !s.unf)
		else $error("software set underflow flag");

	// fault reset must not wipe the flags, only software or power-on may
	AST_FULL_HOLD: assert property (s.full && !(apb_wr && (paddr[7:0] == `PRS_OFS_STACK_POINTER))
		|=> s.full)
		else $error("full flag dropped");

	AST_UNF_HOLD: assert property (s.unf && !(apb_wr && (paddr[7:0] == `PRS_OFS_STACK_POINTER))
		|=> s.unf)
		else $error("underflow flag dropped");

	// ----------------------------------------
	// coverage
	// ----------------------------------------

	COV_FULL: cover property (do_push && (s.sp == 5'h1E) && !stack_fault_reset_enable);
	COV_UNDERFLOW: cover property (do_pop && (s.sp == `PRS_SP_RESET));
	COV_FAULT: cover property (s.fault);
	COV_IRQ_LO: cover property (core_req.op == prs_pkg::OP_IRQ_LO);
	COV_RET_POP: cover property ((core_req.op == prs_pkg::OP_RET) && (s.sp != `PRS_SP_RESET));

endmodule : prs_top

/* verif/prs_core_model.sv */
`timescale 1ns/1ps

// ----
// core fetch and execute side
// ----
module prs_core_model (
	input wire prs_pkg::prs_op_e cmd_op,
	input wire logic [20:0] cmd_target,
	input wire logic [20:0] fetch_addr,
	output prs_pkg::prs_core_req_s core_req,
	output logic [15:0] fetch_data
);
	// bench raises interrupts only while no stack register access is under way
	assign core_req = '{op: cmd_op, target: cmd_target};
	// content tied to address, so a stale or unblanked fetch shows
	assign fetch_data = fetch_addr[16:1] ^ 16'hA5C3;
endmodule : prs_core_model

/* verif/test_program_counter_return_stack.sv */
`timescale 1ns/1ps
`include "prs_regs.svh"

module test_program_counter_return_stack;
	logic pclk;
	logic presetn;
	logic [31:0] paddr;
	logic psel;
	logic penable;
	logic pwrite;
	logic [31:0] pwdata;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	prs_pkg::prs_core_req_s core_req;
	prs_pkg::prs_op_e cmd_op;
	logic [20:0] cmd_target;
	logic ext_set_enable;
	logic [15:0] fetch_data;
	logic [63:0] cfg_image;
	logic [20:0] fetch_addr;
	logic [15:0] fetch_word;
	logic stack_fault_reset;
	logic [31:0] rd_v;
	logic rd_e;
	int n_fault;
	int n_fail;
	int n_checks;

	prs_top dut (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
		.penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .core_req(core_req),
		.ext_set_enable(ext_set_enable), .fetch_data(fetch_data), .cfg_image(cfg_image),
		.fetch_addr(fetch_addr), .fetch_word(fetch_word),
		.stack_fault_reset(stack_fault_reset));
	prs_core_model core (.cmd_op(cmd_op), .cmd_target(cmd_target), .fetch_addr(fetch_addr),
		.core_req(core_req), .fetch_data(fetch_data));

	initial begin
		pclk = 1'b0;
		forever #12.5 pclk = ~pclk;
	end
	always @(posedge pclk) begin
		if (stack_fault_reset === 1'b1) n_fault <= n_fault + 1;
	end

	// ----
	// access tasks
	// ----
	task automatic test_done;
		$display("checks %0d mismatches %0d", n_checks, n_fail);
		if (n_fail == 0 && n_checks > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask : test_done
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			n_fail++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : chk
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= {24'h00_0000, a};
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		rd_v = prdata;
		rd_e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0000_0000);
		chk(rd_v, e);
	endtask : rd
	task automatic op(input prs_pkg::prs_op_e o, input logic [20:0] t);
		@(posedge pclk);
		cmd_op <= o;
		cmd_target <= t;
		@(posedge pclk);
		cmd_op <= prs_pkg::OP_NONE;
	endtask : op
	task automatic pc_is(input logic [20:0] p);
		repeat (3) @(posedge pclk);
		chk({11'h000, fetch_addr}, {11'h000, p});
		chk({16'h0000, fetch_word}, (p > `PRS_PROG_TOP) ? 32'h0 : {16'h0, p[16:1] ^ 16'hA5C3});
	endtask : pc_is
	task automatic sp_is(input logic f, input logic u, input logic [4:0] s);
		rd(`PRS_OFS_STACK_POINTER, {24'h00_0000, f, u, 1'b0, s});
	endtask : sp_is
	task automatic tos_is(input logic [20:0] v);
		rd(`PRS_OFS_TOS_LOW, {24'h00_0000, v[7:0]});
		rd(`PRS_OFS_TOS_HIGH, {24'h00_0000, v[15:8]});
		rd(`PRS_OFS_TOS_UPPER, {27'h000_0000, v[20:16]});
	endtask : tos_is
	task automatic rst(input logic [63:0] c);
		presetn <= 1'b0;
		cfg_image <= c;
		repeat (12) @(posedge pclk);
		presetn <= 1'b1;
		repeat (2) @(posedge pclk);
	endtask : rst

	// ----
	// tests
	// ----
	initial begin
		{presetn, psel, penable, pwrite, ext_set_enable} = 5'h00;
		{paddr, pwdata, cfg_image, cmd_target, n_fault, n_fail, n_checks} = '0;
		cmd_op = prs_pkg::OP_NONE;
		rst(64'h7E7E_1234_5678_BEEE);
		pc_is(21'h0_0000);
		rd(`PRS_OFS_CONFIG_ONE, 32'h0000_BEEE);
		sp_is(1'b0, 1'b0, 5'h00);
		rd(`PRS_OFS_TOS_LOW, 32'h0000_0000);
		op(prs_pkg::OP_SEQ, 21'h0_0000);
		pc_is(21'h0_0002);
		op(prs_pkg::OP_JUMP, 21'h1_2345);
		pc_is(21'h1_2344);
		rd(`PRS_OFS_PC_LOW, 32'h0000_0044);
		rd(`PRS_OFS_PC_HIGH_LATCH, 32'h0000_0023);
		rd(`PRS_OFS_PC_UPPER_LATCH, 32'h0000_0001);
		apb(1'b1, `PRS_OFS_PC_HIGH_LATCH, 32'h0000_0056);
		apb(1'b1, `PRS_OFS_PC_UPPER_LATCH, 32'h0000_000A);
		apb(1'b1, `PRS_OFS_PC_LOW, 32'h0000_0079);
		pc_is(21'h0A_5678);
		apb(1'b1, `PRS_OFS_PC_HIGH_LATCH, 32'h0000_0011);
		op(prs_pkg::OP_CALL, 21'h0_0100);
		pc_is(21'h0_0100);
		sp_is(1'b0, 1'b0, 5'h01);
		tos_is(21'h0A_5678);
		op(prs_pkg::OP_IRQ_HI, 21'h0_0000);
		pc_is(21'h0_0008);
		op(prs_pkg::OP_IRQ_LO, 21'h0_0000);
		pc_is(21'h0_0018);
		op(prs_pkg::OP_UNLINK, 21'h0_0000);
		pc_is(21'h0_0018);
		ext_set_enable <= 1'b1;
		op(prs_pkg::OP_UNLINK, 21'h0_0000);
		pc_is(21'h0_0008);
		sp_is(1'b0, 1'b0, 5'h02);
		op(prs_pkg::OP_RET, 21'h0_0000);
		pc_is(21'h0_0100);
		op(prs_pkg::OP_RET, 21'h0_0000);
		pc_is(21'h0A_5678);
		rd(`PRS_OFS_PC_HIGH_LATCH, 32'h0000_0011);
		op(prs_pkg::OP_RET, 21'h0_0000);
		pc_is(21'h0_0000);
		sp_is(1'b0, 1'b1, 5'h00);
		chk(n_fault, 0);
		apb(1'b1, `PRS_OFS_STACK_POINTER, 32'h0000_0081);
		sp_is(1'b0, 1'b0, 5'h01);
		apb(1'b1, `PRS_OFS_TOS_LOW, 32'h0000_0034);
		apb(1'b1, `PRS_OFS_TOS_HIGH, 32'h0000_0012);
		apb(1'b1, `PRS_OFS_TOS_UPPER, 32'h0000_0001);
		op(prs_pkg::OP_RET, 21'h0_0000);
		pc_is(21'h1_1234);
		for (int i = 0; i < 31; i++) op(prs_pkg::OP_PUSH, 21'h0_0000);
		sp_is(1'b1, 1'b0, 5'h1F);
		op(prs_pkg::OP_JUMP, 21'h0_0200);
		op(prs_pkg::OP_PUSH, 21'h0_0000);
		sp_is(1'b1, 1'b0, 5'h1F);
		tos_is(21'h1_1234);
		op(prs_pkg::OP_JUMP, 21'h0_8000);
		pc_is(21'h0_8000);
		apb(1'b0, 8'h20, 32'h0000_0000);
		chk({31'h0000_0000, rd_e}, 32'h0000_0001);
		chk(rd_v, 32'h0000_0000);
		rst(64'h0000_0000_0000_BEEF);
		sp_is(1'b0, 1'b0, 5'h00);
		op(prs_pkg::OP_JUMP, 21'h0_0300);
		for (int i = 0; i < 31; i++) op(prs_pkg::OP_PUSH, 21'h0_0000);
		pc_is(21'h0_0000);
		chk(n_fault, 1);
		sp_is(1'b1, 1'b0, 5'h00);
		apb(1'b1, `PRS_OFS_STACK_POINTER, 32'h0000_009F);
		tos_is(21'h0_0302);
		apb(1'b1, `PRS_OFS_STACK_POINTER, 32'h0000_0080);
		op(prs_pkg::OP_RET, 21'h0_0000);
		sp_is(1'b1, 1'b1, 5'h00);
		chk(n_fault, 2);
		test_done();
	end

	initial begin
		repeat (20000) @(posedge pclk);
		n_fail++;
		test_done();
	end
endmodule : test_program_counter_return_stack
